// >>> core/mrmf_pkg.sv
// Shared constants, types and functions of the register map and command front end
package mrmf_pkg;

	localparam int ADDR_W    = 10;
	localparam int DATA_W    = 8;
	localparam int NVM_AW    = 8;
	localparam int NUM_PORTS = 3;
	localparam int LOW_COUNT = 200;

	// Port numbers; the lowest number wins arbitration
	localparam logic [1:0] PORT_UART  = 2'h0;
	localparam logic [1:0] PORT_UPPER = 2'h1;
	localparam logic [1:0] PORT_LOWER = 2'h2;

	// Address ranges of the map
	localparam logic [ADDR_W-1:0] LOW_LAST  = 10'h0c7;
	localparam logic [NVM_AW-1:0] LOW_LAST_IDX = 8'hc7;
	localparam logic [ADDR_W-1:0] UP_FIRST  = 10'h100;
	localparam logic [ADDR_W-1:0] UP_LAST   = 10'h2e2;

	// Filter coefficient and spare registers, all plain storage in the lower range
	localparam logic [ADDR_W-1:0] CELL1_FILTER_COEFFICIENT_11     = 10'h05b;
	localparam logic [ADDR_W-1:0] CELL2_FILTER_COEFFICIENT_2      = 10'h060;
	localparam logic [ADDR_W-1:0] CELL2_FILTER_COEFFICIENT_3      = 10'h061;
	localparam logic [ADDR_W-1:0] CELL2_FILTER_COEFFICIENT_9      = 10'h067;
	localparam logic [ADDR_W-1:0] CELL2_FILTER_COEFFICIENT_14     = 10'h06c;
	localparam logic [ADDR_W-1:0] CELL3_FILTER_COEFFICIENT_1      = 10'h06d;
	localparam logic [ADDR_W-1:0] CELL3_FILTER_COEFFICIENT_6      = 10'h072;
	localparam logic [ADDR_W-1:0] CELL3_FILTER_COEFFICIENT_7      = 10'h073;
	localparam logic [ADDR_W-1:0] CELL3_FILTER_COEFFICIENT_12     = 10'h078;
	localparam logic [ADDR_W-1:0] CELL3_FILTER_COEFFICIENT_13     = 10'h079;
	localparam logic [ADDR_W-1:0] CELL4_FILTER_COEFFICIENT_4      = 10'h07e;
	localparam logic [ADDR_W-1:0] CELL4_FILTER_COEFFICIENT_5      = 10'h07f;
	localparam logic [ADDR_W-1:0] CELL4_FILTER_COEFFICIENT_11     = 10'h085;
	localparam logic [ADDR_W-1:0] CELL5_FILTER_COEFFICIENT_2      = 10'h08a;
	localparam logic [ADDR_W-1:0] CELL5_FILTER_COEFFICIENT_3      = 10'h08b;
	localparam logic [ADDR_W-1:0] CELL5_FILTER_COEFFICIENT_9      = 10'h091;
	localparam logic [ADDR_W-1:0] CELL5_FILTER_COEFFICIENT_14     = 10'h096;
	localparam logic [ADDR_W-1:0] CELL6_FILTER_COEFFICIENT_1      = 10'h097;
	localparam logic [ADDR_W-1:0] CELL6_FILTER_COEFFICIENT_6      = 10'h09c;
	localparam logic [ADDR_W-1:0] CELL6_FILTER_COEFFICIENT_7      = 10'h09d;
	localparam logic [ADDR_W-1:0] CELL6_FILTER_COEFFICIENT_12     = 10'h0a2;
	localparam logic [ADDR_W-1:0] CELL6_FILTER_COEFFICIENT_13     = 10'h0a3;
	localparam logic [ADDR_W-1:0] AUXILIARY_FILTER_COEFFICIENT_5  = 10'h0a9;
	localparam logic [ADDR_W-1:0] AUXILIARY_FILTER_COEFFICIENT_11 = 10'h0af;
	localparam logic [ADDR_W-1:0] AUX_CELL_FILTER_COEFFICIENT_3   = 10'h0b5;
	localparam logic [ADDR_W-1:0] AUX_CELL_FILTER_COEFFICIENT_6   = 10'h0b8;
	localparam logic [ADDR_W-1:0] AUX_CELL_FILTER_COEFFICIENT_9   = 10'h0bb;
	localparam logic [ADDR_W-1:0] AUX_CELL_FILTER_COEFFICIENT_14  = 10'h0c0;
	localparam logic [ADDR_W-1:0] UNUSED_SCRATCH_BYTE_6           = 10'h0c1;

	// Upper range registers of the front end
	localparam logic [ADDR_W-1:0] UPPER_TX_FAULT_RST = 10'h134;
	localparam logic [ADDR_W-1:0] FRONTEND_CTRL      = 10'h180;
	localparam logic [ADDR_W-1:0] PORT_STATUS_BASE   = 10'h181;
	localparam logic [ADDR_W-1:0] UPPER_WAIT_STATUS  = 10'h184;
	localparam logic [ADDR_W-1:0] CONFIG_CRC         = 10'h185;

	// Field positions and reset values
	localparam int CTRL_ACCEPT_LSB = 0;
	localparam int CTRL_TX_OFF_LSB = 3;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h07;
	localparam int ST_INIT     = 0;
	localparam int ST_SOF      = 1;
	localparam int ST_FRAMING  = 2;
	localparam int ST_CRC      = 3;
	localparam int ST_TX_OFF   = 4;
	localparam int ST_SURPRISE = 5;
	localparam int WAIT_RST_BIT   = 0;
	localparam int WAIT_SPARE_BIT = 1;
	localparam int WAIT_FLAG_BIT  = 0;

	// Frame layout: init byte, address high, address low, data, crc
	localparam int INIT_CMD_BIT   = 7;
	localparam int INIT_WRITE_BIT = 4;
	localparam logic [2:0] IDX_ADDR_HI = 3'h1;
	localparam logic [2:0] IDX_ADDR_LO = 3'h2;
	localparam logic [2:0] IDX_DATA    = 3'h3;
	localparam logic [2:0] IDX_CRC     = 3'h4;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_SEED = 8'hff;
	localparam logic [7:0] CRC_FULL_MASK  = 8'hff;
	localparam logic [7:0] CRC_SPARE_MASK = 8'h00;

	typedef struct packed {
		logic        valid;
		logic        first;
		logic        framing_bad;
		logic [7:0]  data;
	} mrmf_byte_type;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mrmf_frame_type;

	typedef struct packed {
		logic init;
		logic sof;
		logic framing;
		logic crc;
	} mrmf_fault_type;

	typedef struct packed {
		logic              valid;
		logic [1:0]        port;
		logic [DATA_W-1:0] data;
	} mrmf_resp_type;

	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc8_step

	// Spare scratch byte enters the configuration checksum as zero
	function automatic logic [7:0] crc_mask(input logic [NVM_AW-1:0] addr);
		return (addr == UNUSED_SCRATCH_BYTE_6[NVM_AW-1:0]) ? CRC_SPARE_MASK : CRC_FULL_MASK;
	endfunction : crc_mask

endpackage : mrmf_pkg

// >>> core/mrmf_cmd_buffer.sv
// Command buffer: assembles one port's frame and checks it
`timescale 1ns/1ns
module mrmf_cmd_buffer (
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire mrmf_pkg::mrmf_byte_type   byte_in,
	input  wire logic                      frame_ready,
	output logic                           frame_valid,
	output mrmf_pkg::mrmf_frame_type       frame,
	output mrmf_pkg::mrmf_fault_type       fault
);

	typedef enum logic [1:0] {BUF_IDLE, BUF_COLLECT, BUF_HOLD} mrmf_buf_state_type;

	mrmf_buf_state_type       state;
	mrmf_buf_state_type       next_state;
	logic [2:0]               idx;
	logic [2:0]               next_idx;
	logic [7:0]               crc;
	logic [7:0]               next_crc;
	mrmf_pkg::mrmf_frame_type next_frame;
	mrmf_pkg::mrmf_fault_type next_fault;

	assign frame_valid = (state == BUF_HOLD);

	always_comb begin
		next_state = state;
		next_idx   = idx;
		next_crc   = crc;
		next_frame = frame;
		next_fault = '0;
		case (state)
			BUF_IDLE: begin
				if (byte_in.valid) begin
					if (!byte_in.first) begin
						next_fault.sof = 1'b1;
					end else if (byte_in.framing_bad) begin
						next_fault.framing = 1'b1;
					end else if (!byte_in.data[mrmf_pkg::INIT_CMD_BIT]) begin
						next_fault.init = 1'b1;
					end else begin
						next_frame.write = byte_in.data[mrmf_pkg::INIT_WRITE_BIT];
						next_crc   = mrmf_pkg::crc8_step(mrmf_pkg::CRC_SEED, byte_in.data);
						next_idx   = mrmf_pkg::IDX_ADDR_HI;
						next_state = BUF_COLLECT;
					end
				end
			end
			BUF_COLLECT: begin
				if (byte_in.valid) begin
					// A bad frame is dropped whole and the buffer waits for a fresh start
					if (byte_in.first) begin
						next_fault.sof = 1'b1;
						next_state = BUF_IDLE;
					end else if (byte_in.framing_bad) begin
						next_fault.framing = 1'b1;
						next_state = BUF_IDLE;
					end else if (idx == mrmf_pkg::IDX_CRC) begin
						if (byte_in.data == crc) begin
							next_state = BUF_HOLD;
						end else begin
							next_fault.crc = 1'b1;
							next_state = BUF_IDLE;
						end
					end else begin
						if (idx == mrmf_pkg::IDX_ADDR_HI) begin
							next_frame.addr[mrmf_pkg::ADDR_W-1:8] = byte_in.data[1:0];
						end else if (idx == mrmf_pkg::IDX_ADDR_LO) begin
							next_frame.addr[7:0] = byte_in.data;
						end else begin
							next_frame.data = byte_in.data;
						end
						next_crc = mrmf_pkg::crc8_step(crc, byte_in.data);
						next_idx = idx + 3'h1;
					end
				end
			end
			BUF_HOLD: begin
				// Bytes arriving while the processor is busy are not taken
				if (frame_ready) begin
					next_state = BUF_IDLE;
				end
			end
			default: begin
				next_state = BUF_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= BUF_IDLE;
			idx   <= 3'h0;
			crc   <= 8'h00;
			frame <= '0;
			fault <= '0;
		end else begin
			state <= next_state;
			idx   <= next_idx;
			crc   <= next_crc;
			frame <= next_frame;
			fault <= next_fault;
		end
	end

endmodule : mrmf_cmd_buffer

// >>> core/mrmf_frontend.sv
// Register map and command front end of the stackable monitor
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module mrmf_frontend (
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire mrmf_pkg::mrmf_byte_type uart_byte,
	input  wire mrmf_pkg::mrmf_byte_type upper_chain_port_byte,
	input  wire mrmf_pkg::mrmf_byte_type lower_chain_port_byte,
	input  wire logic                    upper_tx_wait_event,
	input  wire logic [7:0]              nvm_data,
	output logic [7:0]                   nvm_addr,
	output logic                         nvm_rd,
	output logic                         load_done,
	output mrmf_pkg::mrmf_resp_type      resp,
	output logic [7:0]                   cfg_crc,
	output logic                         upper_tx_wait_fault,
	output logic [2:0]                   port_fault_any
);

	typedef enum logic {LDR_LOAD, LDR_RUN} mrmf_ldr_state_type;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	mrmf_pkg::mrmf_byte_type  port_byte [mrmf_pkg::NUM_PORTS];
	mrmf_pkg::mrmf_frame_type buf_frame [mrmf_pkg::NUM_PORTS];
	mrmf_pkg::mrmf_fault_type buf_fault [mrmf_pkg::NUM_PORTS];
	logic [2:0]               buf_valid;
	logic [2:0]               grant;
	logic [1:0]               acc_port;
	mrmf_pkg::mrmf_frame_type sel;
	logic                     acc;
	logic                     allowed;
	logic                     tx_off;
	logic                     surprise;
	logic                     transmit_disabled_violation;
	logic                     exec_wr;
	logic                     exec_rd;
	logic                     wr_low;
	logic                     rd_low;
	logic [7:0]               low_rd;
	logic [7:0]               upper_rd;
	logic [7:0]               rd_value;
	logic [7:0]               ctrl;
	logic [7:0]               status [mrmf_pkg::NUM_PORTS];
	logic [7:0]               stat_set [mrmf_pkg::NUM_PORTS];
	logic [7:0]               stat_clr [mrmf_pkg::NUM_PORTS];
	logic                     wait_spare;
	logic                     wait_clr;
	logic [7:0]               mem [mrmf_pkg::LOW_COUNT];
	logic                     mem_we;
	logic [7:0]               mem_wa;
	logic [7:0]               mem_wd;
	mrmf_ldr_state_type       ldr_state;
	logic [7:0]               load_addr;
	logic [7:0]               scan_addr;
	logic [7:0]               crc_acc;
	logic [7:0]               next_crc_acc;
	logic                     next_wait;

	// Port status addresses are decoded in the read mux and in the clear path
	function automatic logic [mrmf_pkg::ADDR_W-1:0] status_addr(input int port);
		return mrmf_pkg::PORT_STATUS_BASE + port[mrmf_pkg::ADDR_W-1:0];
	endfunction : status_addr

	////////////////////////////////////////////////////////////////////////////////
	// Command buffers, one per port

	assign port_byte[mrmf_pkg::PORT_UART]  = uart_byte;
	assign port_byte[mrmf_pkg::PORT_UPPER] = upper_chain_port_byte;
	assign port_byte[mrmf_pkg::PORT_LOWER] = lower_chain_port_byte;

	for (genvar p = 0; p < mrmf_pkg::NUM_PORTS; p++) begin : g_buf
		mrmf_cmd_buffer u_buf (
			.core_clk    (core_clk),
			.rst         (rst),
			.byte_in     (port_byte[p]),
			.frame_ready (grant[p]),
			.frame_valid (buf_valid[p]),
			.frame       (buf_frame[p]),
			.fault       (buf_fault[p])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration: fixed priority, the host port first

	// Frames wait in their buffers until the factory load is complete
	assign grant[0] = load_done & buf_valid[0];
	assign grant[1] = load_done & buf_valid[1] & ~buf_valid[0];
	assign grant[2] = load_done & buf_valid[2] & ~buf_valid[1] & ~buf_valid[0];
	assign acc      = |grant;
	assign acc_port = grant[1] ? mrmf_pkg::PORT_UPPER :
	                  grant[2] ? mrmf_pkg::PORT_LOWER : mrmf_pkg::PORT_UART;
	assign sel      = buf_frame[acc_port];

	////////////////////////////////////////////////////////////////////////////////
	// Command processor checks

	assign allowed    = ctrl[mrmf_pkg::CTRL_ACCEPT_LSB + int'(acc_port)];
	assign tx_off     = ctrl[mrmf_pkg::CTRL_TX_OFF_LSB + int'(acc_port)];
	assign surprise   = acc & ~allowed;
	assign transmit_disabled_violation = acc & allowed & ~sel.write & tx_off;
	assign exec_wr    = acc & allowed & sel.write;
	assign exec_rd    = acc & allowed & ~sel.write & ~tx_off;
	assign wr_low     = exec_wr & (sel.addr <= mrmf_pkg::LOW_LAST);
	assign rd_low     = sel.addr <= mrmf_pkg::LOW_LAST;

	////////////////////////////////////////////////////////////////////////////////
	// Lower range storage and factory load

	// Every bit of a lower byte is stored, reserved ones too
	assign mem_we = (ldr_state == LDR_LOAD) | wr_low;
	assign mem_wa = (ldr_state == LDR_LOAD) ? load_addr : sel.addr[7:0];
	assign mem_wd = (ldr_state == LDR_LOAD) ? nvm_data : sel.data;
	assign low_rd = mem[sel.addr[7:0]];

	assign nvm_addr  = load_addr;
	assign nvm_rd    = (ldr_state == LDR_LOAD);
	assign load_done = (ldr_state == LDR_RUN);

	// No reset on the array: the loader fills it before any frame is served
	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ldr_state <= LDR_LOAD;
			load_addr <= 8'h00;
		end else if (ldr_state == LDR_LOAD) begin
			load_addr <= load_addr + 8'h01;
			if (load_addr == mrmf_pkg::LOW_LAST_IDX) begin
				ldr_state <= LDR_RUN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration checksum, one byte per cycle over the lower range

	// A write during a pass gives a mixed result; the next pass corrects it
	assign next_crc_acc = mrmf_pkg::crc8_step(crc_acc,
		mem[scan_addr] & mrmf_pkg::crc_mask(scan_addr));

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scan_addr <= 8'h00;
			crc_acc   <= mrmf_pkg::CRC_SEED;
			cfg_crc   <= 8'h00;
		end else if (load_done) begin
			if (scan_addr == mrmf_pkg::LOW_LAST_IDX) begin
				scan_addr <= 8'h00;
				crc_acc   <= mrmf_pkg::CRC_SEED;
				cfg_crc   <= next_crc_acc;
			end else begin
				scan_addr <= scan_addr + 8'h01;
				crc_acc   <= next_crc_acc;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Upper range registers

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl <= mrmf_pkg::CTRL_RESET;
		end else if (exec_wr && sel.addr == mrmf_pkg::FRONTEND_CTRL) begin
			ctrl <= sel.data;
		end
	end

	// Port fault status: set by the buffer and processor, cleared by writing one
	for (genvar p = 0; p < mrmf_pkg::NUM_PORTS; p++) begin : g_stat
		always_comb begin
			stat_set[p] = 8'h00;
			stat_set[p][mrmf_pkg::ST_INIT]     = buf_fault[p].init;
			stat_set[p][mrmf_pkg::ST_SOF]      = buf_fault[p].sof;
			stat_set[p][mrmf_pkg::ST_FRAMING]  = buf_fault[p].framing;
			stat_set[p][mrmf_pkg::ST_CRC]      = buf_fault[p].crc;
			stat_set[p][mrmf_pkg::ST_TX_OFF]   = transmit_disabled_violation & grant[p];
			stat_set[p][mrmf_pkg::ST_SURPRISE] = surprise & grant[p];
		end

		assign stat_clr[p] = (exec_wr && sel.addr == status_addr(p)) ? sel.data : 8'h00;
		assign port_fault_any[p] = |status[p];

		// A fault landing in the clear cycle survives the clear
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				status[p] <= 8'h00;
			end else begin
				status[p] <= (status[p] & ~stat_clr[p]) | stat_set[p];
			end
		end
	end

	// Wait flag of the upper chain transmitter
	assign wait_clr  = exec_wr & (sel.addr == mrmf_pkg::UPPER_TX_FAULT_RST)
	                 & sel.data[mrmf_pkg::WAIT_RST_BIT];
	assign next_wait = upper_tx_wait_event | (upper_tx_wait_fault & ~wait_clr);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			upper_tx_wait_fault <= 1'b0;
			wait_spare          <= 1'b0;
		end else begin
			upper_tx_wait_fault <= next_wait;
			if (exec_wr && sel.addr == mrmf_pkg::UPPER_TX_FAULT_RST) begin
				wait_spare <= sel.data[mrmf_pkg::WAIT_SPARE_BIT];
			end
		end
	end

	// Writes to any other upper address find no storage and change nothing

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	always_comb begin
		upper_rd = 8'h00;
		case (sel.addr)
			mrmf_pkg::FRONTEND_CTRL: begin
				upper_rd = ctrl;
			end
			status_addr(0): begin
				upper_rd = status[0];
			end
			status_addr(1): begin
				upper_rd = status[1];
			end
			status_addr(2): begin
				upper_rd = status[2];
			end
			mrmf_pkg::UPPER_WAIT_STATUS: begin
				upper_rd[mrmf_pkg::WAIT_FLAG_BIT] = upper_tx_wait_fault;
			end
			mrmf_pkg::UPPER_TX_FAULT_RST: begin
				// The reset bit itself always reads zero
				upper_rd[mrmf_pkg::WAIT_SPARE_BIT] = wait_spare;
			end
			mrmf_pkg::CONFIG_CRC: begin
				upper_rd = cfg_crc;
			end
			default: begin
				upper_rd = 8'h00;
			end
		endcase
	end

	assign rd_value = rd_low ? low_rd : upper_rd;

	// A read refused for transmit disable gives no answer at all
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			resp <= '0;
		end else begin
			resp.valid <= exec_rd;
			if (exec_rd) begin
				resp.port <= acc_port;
				resp.data <= rd_value;
			end
		end
	end

endmodule : mrmf_frontend

// >>> sim/mrmf_host_model.sv
// Frame sender standing for the host or a neighbouring chained device
`timescale 1ns/1ns
module mrmf_host_model #(
	parameter int SLOW = 0
) (
	input wire logic		core_clk,
	output mrmf_pkg::mrmf_byte_type	byte_out
);
	initial begin
		byte_out = '{1'b0, 1'b0, 1'b0, 8'h3c};
	end
	////////////////////////////////////////
	function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int i = 0; i < 8; i++) begin
			x = x[7] ? ({x[6:0], 1'b0} ^ mrmf_pkg::CRC_POLY) : {x[6:0], 1'b0};
		end
		return x;
	endfunction : step
	// Kind 1 bad check byte, 2 bad init byte, 3 framing error, 4 no start mark
	task automatic send(input logic wr, input logic [9:0] a, input logic [7:0] d, input int k);
		logic [7:0] b [5];
		b[0] = {k != 2, 2'b00, wr, 4'h0};
		b[1] = {6'h00, a[9:8]};
		b[2] = a[7:0];
		b[3] = d;
		b[4] = step(step(step(step(mrmf_pkg::CRC_SEED, b[0]), b[1]), b[2]), b[3]);
		b[4] = b[4] ^ {7'h00, k == 1};
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			byte_out <= '{1'b1, i == 0 && k != 4, i == 4 && k == 3, b[i]};
			// Slow sender idles between bytes with a line that keeps moving
			if (SLOW != 0) begin
				@(posedge core_clk);
				byte_out <= '{1'b0, 1'b0, 1'b0, ~b[i]};
			end
		end
		@(posedge core_clk);
		byte_out <= '{1'b0, 1'b0, 1'b0, ~b[4]};
	endtask : send
endmodule : mrmf_host_model

// >>> sim/mrmf_frontend_chk.sv
// Port checks of the register map front end
`timescale 1ns/1ns
module mrmf_frontend_chk (
	input wire logic			core_clk,
	input wire logic			rst,
	input wire mrmf_pkg::mrmf_byte_type	uart_byte,
	input wire mrmf_pkg::mrmf_byte_type	upper_chain_port_byte,
	input wire mrmf_pkg::mrmf_byte_type	lower_chain_port_byte,
	input wire logic			upper_tx_wait_event,
	input wire logic [7:0]			nvm_data,
	input wire logic [7:0]			nvm_addr,
	input wire logic			nvm_rd,
	input wire logic			load_done,
	input wire mrmf_pkg::mrmf_resp_type	resp,
	input wire logic [7:0]			cfg_crc,
	input wire logic			upper_tx_wait_fault,
	input wire logic [2:0]			port_fault_any
);
	int unsigned load_cnt;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// Own count of load edges, independent of the loader's address
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			load_cnt <= 0;
		end else if (!load_done) begin
			load_cnt <= load_cnt + 1;
		end
	end
	////////////////////////////////////////
	sequence s_bad(v, fb);
		v && fb && load_done;
	endsequence
	sequence s_flag(f);
		##2 f;
	endsequence
	AST_LOAD_LEN: assert property ($rose(load_done) |-> load_cnt == 200)
		else $error("load length wrong");
	AST_LOAD_RD: assert property (nvm_rd |-> !load_done && nvm_addr <= 8'hc7)
		else $error("load strobe wrong");
	AST_NVM_STEP: assert property (nvm_rd && $past(nvm_rd) && !$past(rst) |->
		nvm_addr == $past(nvm_addr) + 8'h01) else $error("load address step");
	AST_RESP_LOADED: assert property (resp.valid |-> load_done)
		else $error("answer before load");
	AST_RESP_HOLD: assert property (!resp.valid |-> $stable(resp.data) && $stable(resp.port))
		else $error("answer not held");
	AST_WAIT_SET: assert property (upper_tx_wait_event |=> upper_tx_wait_fault)
		else $error("wait flag not set");
	AST_WAIT_CLR: assert property ($fell(upper_tx_wait_fault) |-> !$past(upper_tx_wait_event))
		else $error("wait flag lost");
	AST_DROP_UART: assert property (s_bad(uart_byte.valid, uart_byte.framing_bad) |->
		s_flag(port_fault_any[0])) else $error("uart fault missing");
	AST_DROP_UPPER: assert property (s_bad(upper_chain_port_byte.valid,
		upper_chain_port_byte.framing_bad) |-> s_flag(port_fault_any[1]))
		else $error("upper fault missing");
	AST_DROP_LOWER: assert property (s_bad(lower_chain_port_byte.valid,
		lower_chain_port_byte.framing_bad) |-> s_flag(port_fault_any[2]))
		else $error("lower fault missing");
endmodule : mrmf_frontend_chk
bind mrmf_frontend mrmf_frontend_chk u_chk (.core_clk(core_clk), .rst(rst),
	.uart_byte(uart_byte), .upper_chain_port_byte(upper_chain_port_byte),
	.lower_chain_port_byte(lower_chain_port_byte), .upper_tx_wait_event(upper_tx_wait_event),
	.nvm_data(nvm_data), .nvm_addr(nvm_addr), .nvm_rd(nvm_rd), .load_done(load_done),
	.resp(resp), .cfg_crc(cfg_crc), .upper_tx_wait_fault(upper_tx_wait_fault),
	.port_fault_any(port_fault_any));

// >>> sim/testbench.sv
// Self-checking bench of the register map front end
`timescale 1ns/1ns
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %0t %s", $time, m); end end
module testbench;
	logic				core_clk;
	logic				rst;
	logic				upper_tx_wait_event;
	mrmf_pkg::mrmf_byte_type	pb [3];
	logic [7:0]			nvm_addr;
	logic [7:0]			nvm_data;
	logic				nvm_rd;
	logic				load_done;
	mrmf_pkg::mrmf_resp_type	resp;
	mrmf_pkg::mrmf_resp_type	last_resp;
	logic [7:0]			cfg_crc;
	logic				upper_tx_wait_fault;
	logic [2:0]			port_fault_any;
	logic [7:0]			mirror [200];
	logic [9:0]			regs [29] = '{10'h05b, 10'h060, 10'h061, 10'h067, 10'h06c,
		10'h06d, 10'h072, 10'h073, 10'h078, 10'h079, 10'h07e, 10'h07f, 10'h085, 10'h08a,
		10'h08b, 10'h091, 10'h096, 10'h097, 10'h09c, 10'h09d, 10'h0a2, 10'h0a3, 10'h0a9,
		10'h0af, 10'h0b5, 10'h0b8, 10'h0bb, 10'h0c0, 10'h0c1};
	logic [9:0]			ua [4] = '{10'h100, 10'h2e2, 10'h134, 10'h200};
	logic [7:0]			ue [4] = '{8'h00, 8'h00, 8'h02, 8'h00};
	int				bad_count = 0;
	int				checks_done = 0;
	int				resp_count = 0;
	int				seed;
	logic [7:0]			d;
	// Factory bytes follow the address so a skipped load step shows
	assign nvm_data = nvm_addr ^ 8'h5a;
	mrmf_frontend uut (.core_clk(core_clk), .rst(rst), .uart_byte(pb[0]),
		.upper_chain_port_byte(pb[1]), .lower_chain_port_byte(pb[2]),
		.upper_tx_wait_event(upper_tx_wait_event), .nvm_data(nvm_data), .nvm_addr(nvm_addr),
		.nvm_rd(nvm_rd), .load_done(load_done), .resp(resp), .cfg_crc(cfg_crc),
		.upper_tx_wait_fault(upper_tx_wait_fault), .port_fault_any(port_fault_any));
	mrmf_host_model #(.SLOW(0)) host0 (.core_clk(core_clk), .byte_out(pb[0]));
	mrmf_host_model #(.SLOW(1)) host1 (.core_clk(core_clk), .byte_out(pb[1]));
	mrmf_host_model #(.SLOW(0)) host2 (.core_clk(core_clk), .byte_out(pb[2]));
	////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (resp.valid === 1'b1) begin
			resp_count++;
			last_resp = resp;
		end
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		bad_count++;
		$display("[ERR] %0t watchdog", $time);
		report_and_stop();
	end
	function automatic logic [7:0] fbit(input int k);
		return (k == 1) ? 8'h08 : (k == 2) ? 8'h01 : (k == 3) ? 8'h04 : 8'h02;
	endfunction : fbit
	// Spare byte enters the checksum as zero
	function automatic logic [7:0] exp_crc();
		logic [7:0] c;
		c = 8'hff;
		for (int a = 0; a < 200; a++) begin
			c = host0.step(c, (a == 'hc1) ? 8'h00 : mirror[a]);
		end
		return c;
	endfunction : exp_crc
	task automatic send(input int p, input logic wr, input logic [9:0] a,
		input logic [7:0] dt, input int k);
		case (p)
			0: host0.send(wr, a, dt, k);
			1: host1.send(wr, a, dt, k);
			default: host2.send(wr, a, dt, k);
		endcase
		if (wr && k == 0 && a < 10'h0c8) begin
			mirror[a] = dt;
		end
		repeat (4) @(posedge core_clk);
	endtask : send
	task automatic rd(input int p, input logic [9:0] a, input logic [7:0] e,
		input logic [7:0] m, input bit ans);
		int c0;
		c0 = resp_count;
		send(p, 1'b0, a, 8'h00, 0);
		repeat (6) @(posedge core_clk);
		`CHK(resp_count - c0, int'(ans), "answer count")
		if (ans) begin
			`CHK(last_resp.data & m, e & m, "read data")
			`CHK(last_resp.port, 2'(p), "answer port")
		end
	endtask : rd
	task automatic wait_load();
		for (int n = 0; n < 400 && load_done !== 1'b1; n++) begin
			@(posedge core_clk);
		end
		`CHK(load_done, 1'b1, "load done")
	endtask : wait_load
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////
	initial begin
		seed = 32'h6b11;
		rst = 1'b1;
		upper_tx_wait_event = 1'b0;
		for (int i = 0; i < 200; i++) begin
			mirror[i] = 8'(i) ^ 8'h5a;
		end
		repeat (12) @(posedge core_clk);
		`CHK({nvm_rd, load_done, resp.valid, port_fault_any}, 6'b100000, "reset")
		rst <= 1'b0;
		wait_load();
		rd(0, 10'h180, 8'h07, 8'hff, 1);
		for (int i = 0; i < 29; i++) begin
			rd(0, regs[i], mirror[regs[i]], 8'hff, 1);
			d = 8'($random(seed));
			send(i % 3, 1'b1, regs[i], d, 0);
			rd(0, regs[i], d, 8'hff, 1);
		end
		$display("test map done");
		for (int i = 0; i < 4; i++) begin
			send(0, 1'b1, ua[i], 8'hff, 0);
			rd(0, ua[i], ue[i], 8'hff, 1);
		end
		upper_tx_wait_event <= 1'b1;
		@(posedge core_clk);
		upper_tx_wait_event <= 1'b0;
		repeat (2) @(posedge core_clk);
		`CHK(upper_tx_wait_fault, 1'b1, "wait set")
		rd(0, 10'h184, 8'h01, 8'hff, 1);
		send(0, 1'b1, 10'h134, 8'h01, 0);
		`CHK(upper_tx_wait_fault, 1'b0, "wait clear")
		$display("test upper range done");
		for (int p = 0; p < 3; p++) begin
			for (int k = 1; k < 5; k++) begin
				send(p, 1'b1, 10'h05b, ~mirror[8'h5b], k);
				`CHK(port_fault_any[p], 1'b1, "fault flag")
				rd(0, 10'h181 + 10'(p), fbit(k), fbit(k), 1);
				send(0, 1'b1, 10'h181 + 10'(p), 8'hff, 0);
				`CHK(port_fault_any[p], 1'b0, "fault clear")
			end
		end
		rd(0, 10'h05b, mirror[8'h5b], 8'hff, 1);
		$display("test bad frames done");
		send(0, 1'b1, 10'h180, 8'h03, 0);
		send(2, 1'b1, 10'h05b, 8'h11, 5);
		rd(0, 10'h183, 8'h20, 8'h20, 1);
		rd(0, 10'h05b, mirror[8'h5b], 8'hff, 1);
		send(0, 1'b1, 10'h180, 8'h0f, 0);
		rd(0, 10'h05b, 8'h00, 8'h00, 0);
		rd(1, 10'h181, 8'h10, 8'h10, 1);
		send(0, 1'b1, 10'h180, 8'h07, 0);
		rd(0, 10'h180, 8'h07, 8'hff, 1);
		$display("test processor done");
		repeat (420) @(posedge core_clk);
		`CHK(cfg_crc, exp_crc(), "checksum")
		send(0, 1'b1, 10'h0c1, ~mirror[8'hc1], 0);
		repeat (420) @(posedge core_clk);
		`CHK(cfg_crc, exp_crc(), "checksum spare")
		$display("test checksum done");
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		`CHK({nvm_rd, load_done, upper_tx_wait_fault}, 3'b100, "second reset")
		rst <= 1'b0;
		wait_load();
		rd(0, 10'h05b, 8'h5b ^ 8'h5a, 8'hff, 1);
		$display("test reload done");
		report_and_stop();
	end
endmodule : testbench
